// ---- design/sms_pkg.sv ----
// package for the standby-mode sequencer: offsets, fields, states, carriers
`default_nettype none
package sms_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on the axi4-lite slave)
    // ------------------------------------------------------------------
    localparam logic [7:0] SMS_OFF_PWR    = 8'h00;  // power_ctrl_reg
    localparam logic [7:0] SMS_OFF_WDT    = 8'h04;  // watchdog_ctrl_reg
    localparam logic [7:0] SMS_OFF_OSC3   = 8'h08;  // osc_ctrl_reg_three
    localparam logic [7:0] SMS_OFF_BTCTL  = 8'h0c;  // base timer setup
    localparam logic [7:0] SMS_OFF_STATUS = 8'h10;  // mode, read only

    localparam int SMS_REG_W = 8;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int PWR_HALT_BIT  = 0;
    localparam int PWR_HOLD_BIT  = 1;
    localparam int PWR_XTAL_BIT  = 2;
    localparam int WDT_SEL3_BIT  = 3;
    localparam int WDT_SEL4_BIT  = 4;
    localparam int WDT_CLR5_BIT  = 5;
    localparam int WDT_LRC_BIT   = 6;   // low-speed rc enable from the watchdog
    localparam int OSC3_CLR6_BIT = 6;
    localparam int BT_RUN_BIT    = 0;
    localparam int BT_SRC_BIT    = 1;   // 1: base timer clocked by low-speed rc

    localparam logic [7:0] SMS_PWR_RST  = 8'h00;
    localparam logic [7:0] SMS_WDT_RST  = 8'h00;
    localparam logic [7:0] SMS_OSC3_RST = 8'h00;
    localparam logic [7:0] SMS_BT_RST   = 8'h00;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // operating modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        SMS_NORMAL = 5'h01,
        SMS_HALT   = 5'h02,
        SMS_HOLD   = 5'h04,
        SMS_XHOLD  = 5'h08,
        SMS_RESET  = 5'h10
    } sms_mode_t;

    // wake-up request lines from the interrupt sources
    typedef struct packed {
        logic base_timer;
        logic port_zero;
        logic ext_irq_four;
        logic ext_irq_two;
        logic ext_irq_one;
        logic ext_irq_zero;
    } sms_wake_t;

    localparam int SMS_WAKE_W = $bits(sms_wake_t);

    // clock and peripheral controls driven toward the oscillators
    typedef struct packed {
        logic lrc_osc_en;
        logic main_osc_en;
        logic base_timer_en;
        logic periph_en;
        logic serial_stop;
    } sms_clk_ctl_t;

endpackage : sms_pkg
`default_nettype wire

// ---- design/sms_sync.sv ----
// two-flop synchroniser for a bundle of level inputs
`default_nettype none
module sms_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // sms_sync
`default_nettype wire

// ---- design/sms_sequencer.sv ----
// standby-mode sequencer: halt, hold and crystal hold entry and exit
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module sms_sequencer
    import sms_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output var  logic         s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output var  logic         s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]   s_axi_bresp,
    output var  logic         s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output var  logic         s_axi_arready,
    output var  logic [31:0]  s_axi_rdata,
    output var  logic [1:0]   s_axi_rresp,
    output var  logic         s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // core and wake-up sources
    input  wire sms_wake_t    wake_req,
    input  wire logic         irq_accept,
    input  wire logic         reset_cond,
    // toward the core and oscillators
    output var  logic         cpu_run,
    output var  logic         core_reset,
    output var  sms_clk_ctl_t clk_ctl,
    output var  sms_mode_t    mode
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // decode the mode that software asked for, normal when none
    function automatic sms_mode_t req_mode(input logic [SMS_REG_W-1:0] p);
        if (p[PWR_HOLD_BIT])
            req_mode = p[PWR_XTAL_BIT] ? SMS_XHOLD : SMS_HOLD;
        else if (p[PWR_HALT_BIT])
            req_mode = SMS_HALT;
        else
            req_mode = SMS_NORMAL;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [SMS_WAKE_W:0] pins_sync;
    sms_wake_t           wake_s;
    logic                reset_s;

    sms_sync #(.WIDTH(SMS_WAKE_W + 1)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({reset_cond, wake_req}),
        .sync_out (pins_sync)
    );

    assign wake_s  = sms_wake_t'(pins_sync[SMS_WAKE_W-1:0]);
    assign reset_s = pins_sync[SMS_WAKE_W];

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic [7:0]  aw_addr_q;
    logic        aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_have_q;
    logic        wr_fire;
    logic        wr_hit;
    logic        rd_fire;

    // readies are flops: low from acceptance until the answer is taken,
    // so a second transfer cannot start while one is still in flight
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_arready <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_wready <= 1'b1;
            if (rd_fire)
                s_axi_arready <= 1'b0;
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_arready <= 1'b1;
        end
    end
    // write happens once both halves are held and no response is pending
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit  = (aw_addr_q == SMS_OFF_PWR) || (aw_addr_q == SMS_OFF_WDT) ||
                     (aw_addr_q == SMS_OFF_OSC3) || (aw_addr_q == SMS_OFF_BTCTL);
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    // address and data captured in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_have_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_have_q <= 1'b0;
        end
    end

    // write response, slverr on unmapped or read-only address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // registers and sequencing state
    // ------------------------------------------------------------------
    logic [SMS_REG_W-1:0] pwr_q;
    logic [SMS_REG_W-1:0] wdt_q;
    logic [SMS_REG_W-1:0] osc3_q;
    logic [SMS_REG_W-1:0] bt_q;
    sms_mode_t            mode_d;
    logic                 pwr_wr;
    logic                 wake_hold;
    logic                 wake_xhold;
    logic                 entering;
    logic                 abort;
    logic                 lrc_keep_q;
    logic                 lrc_entry_q;

    // only the low byte carries a register
    assign pwr_wr = wr_fire && (aw_addr_q == SMS_OFF_PWR) && w_strb_q[0];

    // wake sources per hold flavour
    assign wake_hold  = wake_s.ext_irq_zero | wake_s.ext_irq_one |
                        wake_s.ext_irq_two | wake_s.ext_irq_four | wake_s.port_zero;
    assign wake_xhold = wake_hold | wake_s.base_timer;

    // a fresh mode request while stopped counts as an abort, like the reset source
    assign abort = reset_s || pwr_wr;
    assign entering = (mode == SMS_NORMAL) && (req_mode(pwr_q) != SMS_NORMAL);

    // mode sequencing
    always_comb
    begin
        mode_d = mode;
        unique case (mode)
            SMS_NORMAL: mode_d = req_mode(pwr_q);
            SMS_HALT:
            begin
                if (abort)
                    mode_d = SMS_RESET;
                else if (irq_accept)
                    mode_d = SMS_NORMAL;
            end
            SMS_HOLD:
            begin
                if (abort)
                    mode_d = SMS_RESET;
                else if (wake_hold)
                    mode_d = SMS_HALT;
            end
            SMS_XHOLD:
            begin
                if (abort)
                    mode_d = SMS_RESET;
                else if (wake_xhold)
                    mode_d = SMS_HALT;
            end
            SMS_RESET:  mode_d = SMS_NORMAL;
            default:    mode_d = SMS_RESET;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode <= SMS_NORMAL;
        else
            mode <= mode_d;
    end

    // power control: hardware updates applied after the software write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwr_q <= SMS_PWR_RST;
        else if (mode == SMS_RESET)
            pwr_q <= SMS_PWR_RST;
        else
        begin
            if (pwr_wr)
                pwr_q <= w_data_q[SMS_REG_W-1:0];
            if (entering && (mode_d != SMS_HALT))
                pwr_q[PWR_HALT_BIT] <= 1'b1;
            if ((mode == SMS_HALT) && (mode_d == SMS_NORMAL))
                pwr_q[PWR_HALT_BIT] <= 1'b0;
            if (((mode == SMS_HOLD) || (mode == SMS_XHOLD)) && (mode_d == SMS_HALT))
                pwr_q[PWR_HOLD_BIT] <= 1'b0;
        end
    end

    // watchdog control byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wdt_q <= SMS_WDT_RST;
        else
        begin
            if (wr_fire && (aw_addr_q == SMS_OFF_WDT) && w_strb_q[0])
                wdt_q <= w_data_q[SMS_REG_W-1:0];
            if (entering && !wdt_q[WDT_SEL4_BIT] && wdt_q[WDT_SEL3_BIT])
                wdt_q[WDT_CLR5_BIT] <= 1'b0;
        end
    end

    // oscillator control three and base timer setup
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            osc3_q <= SMS_OSC3_RST;
            bt_q   <= SMS_BT_RST;
        end
        else
        begin
            if (wr_fire && (aw_addr_q == SMS_OFF_OSC3) && w_strb_q[0])
                osc3_q <= w_data_q[SMS_REG_W-1:0];
            if (wr_fire && (aw_addr_q == SMS_OFF_BTCTL) && w_strb_q[0])
                bt_q <= w_data_q[SMS_REG_W-1:0];
            if (entering && (mode_d == SMS_HOLD))
                osc3_q[OSC3_CLR6_BIT] <= 1'b0;
        end
    end

    // snapshot of the low-speed rc at crystal hold entry
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lrc_keep_q  <= 1'b0;
            lrc_entry_q <= 1'b0;
        end
        else if (entering && (mode_d == SMS_XHOLD))
        begin
            lrc_keep_q  <= bt_q[BT_RUN_BIT] && bt_q[BT_SRC_BIT];
            lrc_entry_q <= clk_ctl.lrc_osc_en;
        end
    end

    // ------------------------------------------------------------------
    // outputs toward core and oscillators, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_run    <= 1'b1;
            core_reset <= 1'b0;
            clk_ctl    <= '0;
        end
        else
        begin
            cpu_run    <= (mode_d == SMS_NORMAL);
            core_reset <= (mode_d == SMS_RESET);
            clk_ctl.main_osc_en   <= (mode_d == SMS_NORMAL) || (mode_d == SMS_HALT);
            clk_ctl.periph_en     <= (mode_d == SMS_NORMAL) || (mode_d == SMS_HALT);
            clk_ctl.serial_stop   <= (mode_d == SMS_HALT);
            clk_ctl.base_timer_en <= bt_q[BT_RUN_BIT] && (mode_d != SMS_HOLD);
            // the watchdog bit stays in charge in standby, except the crystal
            // hold case where the base timer depends on the running rc
            if ((mode_d == SMS_XHOLD) && (lrc_keep_q || (entering &&
                bt_q[BT_RUN_BIT] && bt_q[BT_SRC_BIT])))
                clk_ctl.lrc_osc_en <= entering ? clk_ctl.lrc_osc_en
                                               : lrc_entry_q;
            else
                clk_ctl.lrc_osc_en <= wdt_q[WDT_LRC_BIT];
        end
    end

    // read path, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= AXI_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= AXI_OKAY;
            unique case (s_axi_araddr)
                SMS_OFF_PWR:    s_axi_rdata <= {24'h000000, pwr_q};
                SMS_OFF_WDT:    s_axi_rdata <= {24'h000000, wdt_q};
                SMS_OFF_OSC3:   s_axi_rdata <= {24'h000000, osc3_q};
                SMS_OFF_BTCTL:  s_axi_rdata <= {24'h000000, bt_q};
                SMS_OFF_STATUS: s_axi_rdata <= {27'h0000000, mode};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= AXI_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // sms_sequencer
`default_nettype wire

// ---- tb/sms_checker.sv ----
// port assertions for the standby-mode sequencer
`default_nettype none
module sms_checker
    import sms_pkg::*;
(
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // inputs watched
    input wire logic         s_axi_awvalid,
    input wire sms_wake_t    wake_req,
    input wire logic         irq_accept,
    input wire logic         reset_cond,
    // outputs watched
    input wire logic         cpu_run,
    input wire logic         core_reset,
    input wire sms_clk_ctl_t clk_ctl,
    input wire sms_mode_t    mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // steps: no abort near, then a wake or accept
    // ----------------------------------------------------------------
    // sync delay is two edges, so look back that far for aborts
    sequence quiet_s;
        !reset_cond && !$past(reset_cond) && !$past(reset_cond, 2)
        && !s_axi_awvalid && !$past(s_axi_awvalid);
    endsequence
    sequence hold_wake_s;
        mode == SMS_HOLD && (|$past(wake_req[4:0], 2));
    endsequence
    halt_exit_a:
    assert property (quiet_s ##0 (mode == SMS_HALT && irq_accept)
        |=> mode == SMS_NORMAL && cpu_run) else $error("halt exit wrong");
    hold_wake_a:
    assert property (quiet_s ##0 hold_wake_s |=> mode == SMS_HALT)
        else $error("hold wake wrong");
    hold_stay_a:
    assert property (quiet_s ##0 (mode == SMS_HOLD && !(|$past(wake_req[4:0], 2)))
        |=> mode == SMS_HOLD) else $error("hold left without wake");
    xhold_wake_a:
    assert property (quiet_s ##0 (mode == SMS_XHOLD && (|$past(wake_req, 2)))
        |=> mode == SMS_HALT) else $error("crystal hold wake wrong");
    abort_rst_a:
    assert property ((mode inside {SMS_HALT, SMS_HOLD, SMS_XHOLD})
        && $past(reset_cond, 2) |=> mode == SMS_RESET) else $error("no abort");
    rst_pulse_a:
    assert property (mode == SMS_RESET |-> core_reset ##1
        (mode == SMS_NORMAL && !core_reset)) else $error("reset pulse wrong");
    halt_out_a:
    assert property (mode == SMS_HALT |-> clk_ctl.serial_stop && clk_ctl.periph_en
        && !cpu_run) else $error("halt outputs wrong");
    norm_run_a:
    assert property (mode == SMS_NORMAL |-> cpu_run && !clk_ctl.serial_stop)
        else $error("normal outputs wrong");
endmodule // sms_checker
bind sms_sequencer sms_checker chk (
    .aclk, .aresetn, .s_axi_awvalid, .wake_req, .irq_accept, .reset_cond,
    .cpu_run, .core_reset, .clk_ctl, .mode
);
`default_nettype wire

// ---- tb/sms_core_model.sv ----
// cpu core and wake source model facing the sequencer
`default_nettype none
module sms_core_model
    import sms_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // bench controls
    input  wire sms_wake_t  wake_src,
    input  wire logic       pend,
    input  wire logic [3:0] lat,
    // sequencer side
    input  wire sms_mode_t  mode,
    output var  sms_wake_t  wake_req,
    output var  logic       irq_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // wake lines are plain levels from the sources
    always_ff @(posedge aclk)
        wake_req <= wake_src;
    // core takes a pending request only while halted, lat cycles late
    always_ff @(posedge aclk)
    begin
        if (!aresetn || mode != SMS_HALT || irq_accept)
        begin
            wait_q     <= 4'h0;
            irq_accept <= 1'b0;
        end
        else if (pend && wait_q == lat)
            irq_accept <= 1'b1;
        else if (pend)
            wait_q <= wait_q + 4'h1;
    end
endmodule // sms_core_model
`default_nettype wire

// ---- tb/sms_sequencer_tb.sv ----
// self-checking bench for the standby-mode sequencer
`default_nettype none
module sms_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sms_pkg::*;
    logic         aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]   s_axi_wstrb = 4'hf, lat = 4'h0;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pend = 1'b0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic         s_axi_rvalid, irq_accept, reset_cond = 1'b0, cpu_run, core_reset;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rs;
    sms_wake_t    wake_src = 6'h00, wake_req;
    sms_clk_ctl_t clk_ctl;
    sms_mode_t    mode;
    int           failures = 0, total_checks = 0, cyc = 0, n_rst = 0;
    // ----------------------------------------------------------------
    // clock, instances, monitors
    // ----------------------------------------------------------------
    always #4 aclk = ~aclk;
    sms_sequencer dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wake_req,
        .irq_accept, .reset_cond, .cpu_run, .core_reset, .clk_ctl, .mode
    );
    sms_core_model core (
        .aclk, .aresetn, .wake_src, .pend, .lat, .mode, .wake_req, .irq_accept
    );
    // reset pulse lasts one cycle, so count it mid-cycle
    always @(negedge aclk)
        if (core_reset === 1'b1)
            n_rst++;
    // hang guard, well above the few hundred cycles needed
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // handshakes sampled mid-cycle, released at the edge that takes them
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        @(negedge aclk);
        chk($sformatf("bresp %h", a), er, rs);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
        @(negedge aclk);
        chk($sformatf("rdata %h", a), ed, rd);
        chk($sformatf("rresp %h", a), er, rs);
    endtask
    task automatic wait_mode(input sms_mode_t m);
        do @(negedge aclk); while (mode !== m);
    endtask
    task automatic enter(input logic [31:0] p, input sms_mode_t m);
        axw(SMS_OFF_PWR, p, AXI_OKAY);
        wait_mode(m);
    endtask
    // ep: power byte left after the halt exit clears only bit 0
    task automatic leave(input logic [3:0] l, input logic [31:0] ep);
        lat <= l;
        pend <= 1'b1;
        wait_mode(SMS_NORMAL);
        pend <= 1'b0;
        chk("cpu_run", 32'h1, cpu_run);
        axr(SMS_OFF_PWR, ep, AXI_OKAY);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, read-only status, unmapped slot
        axr(SMS_OFF_PWR, SMS_PWR_RST, AXI_OKAY);
        axr(SMS_OFF_WDT, SMS_WDT_RST, AXI_OKAY);
        axr(SMS_OFF_OSC3, SMS_OSC3_RST, AXI_OKAY);
        axr(SMS_OFF_BTCTL, SMS_BT_RST, AXI_OKAY);
        axr(SMS_OFF_STATUS, SMS_NORMAL, AXI_OKAY);
        axr(8'h14, 32'h0, AXI_SLVERR);
        axw(SMS_OFF_STATUS, 32'h2, AXI_SLVERR);
        // halt: watchdog bit 5 cleared, osc3 untouched
        axw(SMS_OFF_WDT, 32'h68, AXI_OKAY);
        axw(SMS_OFF_OSC3, 32'h40, AXI_OKAY);
        enter(32'h01, SMS_HALT);
        axr(SMS_OFF_WDT, 32'h48, AXI_OKAY);
        axr(SMS_OFF_OSC3, 32'h40, AXI_OKAY);
        chk("lrc", 32'h1, clk_ctl.lrc_osc_en);
        chk("serial", 32'h1, clk_ctl.serial_stop);
        chk("clk_ctl", 32'h1b, clk_ctl);
        leave(4'h5, 32'h0);
        // hold: each wake line, base timer must not wake
        for (int i = 0; i < 5; i++)
        begin
            axw(SMS_OFF_WDT, 32'h28, AXI_OKAY);
            axw(SMS_OFF_OSC3, 32'h40, AXI_OKAY);
            enter(32'h02, SMS_HOLD);
            axr(SMS_OFF_PWR, 32'h03, AXI_OKAY);
            axr(SMS_OFF_WDT, 32'h08, AXI_OKAY);
            axr(SMS_OFF_OSC3, 32'h00, AXI_OKAY);
            chk("lrc", 32'h0, clk_ctl.lrc_osc_en);
            chk("clk_ctl", 32'h00, clk_ctl);
            wake_src <= 6'h20;
            repeat (8) @(negedge aclk);
            chk("mode", SMS_HOLD, mode);
            wake_src <= 6'h20 | (6'h01 << i);
            wait_mode(SMS_HALT);
            axr(SMS_OFF_PWR, 32'h01, AXI_OKAY);
            wake_src <= 6'h00;
            leave(4'(i), 32'h0);
        end
        // crystal hold with base timer on the low-speed rc
        axw(SMS_OFF_BTCTL, 32'h03, AXI_OKAY);
        axw(SMS_OFF_WDT, 32'h40, AXI_OKAY);
        axw(SMS_OFF_OSC3, 32'h40, AXI_OKAY);
        enter(32'h06, SMS_XHOLD);
        axr(SMS_OFF_PWR, 32'h07, AXI_OKAY);
        axr(SMS_OFF_OSC3, 32'h40, AXI_OKAY);
        axw(SMS_OFF_WDT, 32'h00, AXI_OKAY);
        chk("lrc", 32'h1, clk_ctl.lrc_osc_en);
        chk("clk_ctl", 32'h14, clk_ctl);
        wake_src <= 6'h20;
        wait_mode(SMS_HALT);
        axr(SMS_OFF_PWR, 32'h05, AXI_OKAY);
        chk("lrc", 32'h0, clk_ctl.lrc_osc_en);
        wake_src <= 6'h00;
        leave(4'h0, 32'h04);
        // reset source in halt, power write in hold
        for (int i = 0; i < 2; i++)
        begin
            enter(i ? 32'h02 : 32'h01, i ? SMS_HOLD : SMS_HALT);
            n_rst = 0;
            if (i)
                axw(SMS_OFF_PWR, 32'h01, AXI_OKAY);
            else
            begin
                @(posedge aclk);
                reset_cond <= 1'b1;
                wait_mode(SMS_RESET);
                @(posedge aclk);
                reset_cond <= 1'b0;
            end
            wait_mode(SMS_NORMAL);
            chk("resets", 32'h1, n_rst);
            axr(SMS_OFF_PWR, 32'h0, AXI_OKAY);
        end
        wrap_up();
    end
endmodule // sms_sequencer_tb
`default_nettype wire
